// ### pd_hotswap_sequencer.sv
`timescale 1ns/100ps
module pd_hotswap_sequencer
  import pd_hotswap_pkg::*;
#(
  parameter int OVL_CYCLES = OVL_DEGLITCH_CYC,
  parameter int DELAY_CYCLES = INRUSH_DELAY_CYC,
  parameter int STATUS_CYCLES = STATUS_DELAY_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire pd_hotswap_pkg::sense_t senseRaw,
  input wire logic inrush_delay_select,
  input wire logic sourceIsType34,
  input wire logic [1:0] allocPower,
  output pd_hotswap_pkg::drive_t drive,
  output logic detectSuppress,
  output logic power_good_out,
  output logic power_good_oe,
  output pd_hotswap_pkg::code_t status,
  output logic statusOe
);
  import pd_hotswap_pkg::*;

  // refuse counts below one or that the shared counter width cannot reach
  if (OVL_CYCLES < 1 || DELAY_CYCLES < 1
      || STATUS_CYCLES < 1) begin : g_bad_count
    $error("cycle counts must be at least one");
  end
  if (OVL_CYCLES >= (1 << CNT_W)
      || DELAY_CYCLES >= (1 << CNT_W)) begin : g_bad_width
    $error("cycle count too wide for counter");
  end
  if (STATUS_CYCLES >= (1 << CNT_W)) begin : g_bad_status
    $error("status delay too wide for counter");
  end

  localparam logic [CNT_W-1:0] OVL_MAX = CNT_W'(OVL_CYCLES);
  localparam logic [CNT_W-1:0] DLY_MAX = CNT_W'(DELAY_CYCLES);
  localparam logic [CNT_W-1:0] STA_MAX = CNT_W'(STATUS_CYCLES);

  typedef struct packed {
    sense_t s1;
    sense_t s2;
    sense_t s3;
    logic sel1;
    logic sel2;
    logic sel3;
    sense_t sense;
    logic delayOpen;
    phase_t phase;
    logic skipDelay;
    logic pgReleased;
    logic [CNT_W-1:0] ovlCount;
    logic [CNT_W-1:0] delayCount;
    logic [CNT_W-1:0] statusCount;
    logic statusActive;
    code_t code;
    drive_t drv;
    logic detSup;
  } state_t;

  state_t q;
  state_t next_q;

  function automatic sense_t agree(sense_t held, sense_t a, sense_t b);
    sense_t r;
    r = held;
    for (int i = 0; i < $bits(sense_t); i++) begin
      if (a[i] == b[i])
        r[i] = a[i];
    end
    return r;
  endfunction

  // low-active code of source type and allocated power
  function automatic code_t encode(logic t34, logic [1:0] p);
    code_t c;
    c.sourceTypeN = ~t34;
    c.allocPowerHighN = 1'b1;
    c.allocPowerLowN = 1'b1;
    case (p)
      ALLOC_LOW: begin
      end
      ALLOC_MID: c.allocPowerLowN = 1'b0;
      ALLOC_HIGH: c.allocPowerHighN = 1'b0;
      ALLOC_HPWR: begin
        // granted high-power source: low, low, high
        c.allocPowerHighN = 1'b0;
        c.allocPowerLowN = 1'b0;
        c.sourceTypeN = 1'b1;
      end
      default: begin
      end
    endcase
    return c;
  endfunction

  logic forceOff;
  logic ovlTrip;

  always_comb begin
    next_q = q;
    next_q.s1 = senseRaw;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.sel1 = inrush_delay_select;
    next_q.sel2 = q.sel1;
    next_q.sel3 = q.sel2;
    next_q.sense = agree(q.sense, q.s2, q.s3);
    if (q.sel2 == q.sel3)
      next_q.delayOpen = q.sel2;

    // disable pin only counts while supply is in range
    forceOff = (q.sense.disableLow && !q.sense.uvloFall)
      || q.sense.overTemp || q.sense.uvloFall;

    if (q.sense.uvloFall || !q.sense.overload)
      next_q.ovlCount = '0;
    else if (q.ovlCount != OVL_MAX)
      next_q.ovlCount = q.ovlCount + 1'b1;
    ovlTrip = q.sense.overload && q.ovlCount == OVL_MAX
      && !q.sense.uvloFall;

    case (q.phase)
      PH_OFF: begin
        next_q.delayCount = '0;
        next_q.skipDelay = 1'b0;
        // rising supply always starts with inrush limit
        if (q.sense.uvloRise && !forceOff) begin
          next_q.phase = PH_INRUSH;
          next_q.pgReleased = 1'b0;
        end
      end
      PH_INRUSH: begin
        if (q.delayCount != DLY_MAX)
          next_q.delayCount = q.delayCount + 1'b1;
        if (q.sense.overTemp)
          next_q.phase = PH_HOT;
        else if (forceOff)
          next_q.phase = PH_OFF;
        else if (q.sense.inrushDone && (q.skipDelay || !q.delayOpen
            || q.delayCount == DLY_MAX)) begin
          next_q.phase = PH_RUN;
          next_q.pgReleased = 1'b1;
        end
      end
      PH_RUN: begin
        if (q.sense.overTemp)
          next_q.phase = PH_HOT;
        else if (forceOff)
          next_q.phase = PH_OFF;
        else if (ovlTrip) begin
          next_q.phase = PH_INRUSH;
          next_q.pgReleased = 1'b0;
          next_q.skipDelay = 1'b1;
        end
      end
      PH_HOT: begin
        if (!q.sense.overTemp) begin
          next_q.phase = PH_INRUSH;
          next_q.pgReleased = 1'b0;
          next_q.delayCount = '0;
          next_q.skipDelay = 1'b0;
        end
      end
      default: next_q.phase = PH_OFF;
    endcase

    // lockout never clears power-good: this branch only fires when it is already clear
    if (q.sense.uvloFall && !q.sense.uvloRise && q.phase == PH_OFF
        && !q.pgReleased)
      next_q.pgReleased = 1'b0;

    if (!q.pgReleased) begin
      next_q.statusCount = '0;
      next_q.statusActive = 1'b0;
    end else if (!q.statusActive) begin
      if (q.statusCount == STA_MAX)
        next_q.statusActive = 1'b1;
      else
        next_q.statusCount = q.statusCount + 1'b1;
    end
    next_q.code = next_q.statusActive
      ? encode(sourceIsType34, allocPower) : 3'h7;

    next_q.drv.passEnable = (next_q.phase == PH_INRUSH
      || next_q.phase == PH_RUN) && !forceOff;
    next_q.drv.inrushLimit = next_q.phase != PH_RUN;
    next_q.drv.classRegEnable = !q.sense.overTemp
      && !q.sense.disableLow;
    next_q.drv.mpsEnable = !q.sense.overTemp
      && next_q.phase == PH_RUN;
    next_q.detSup = q.sense.disableLow && q.phase == PH_OFF;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
      q.s1.uvloFall <= 1'b1;
      q.s2.uvloFall <= 1'b1;
      q.s3.uvloFall <= 1'b1;
      q.sense.uvloFall <= 1'b1;
      q.drv.inrushLimit <= 1'b1;
      q.code <= 3'h7;
      q.phase <= PH_OFF;
    end else begin
      q <= next_q;
    end
  end

  assign drive = q.drv;
  assign detectSuppress = q.detSup;
  assign power_good_out = 1'b0;
  assign power_good_oe = !q.pgReleased;
  assign status = q.code;
  assign statusOe = q.statusActive;

  a_ovl_trip_pg: assert property (
    @(posedge clk) disable iff (!resetn)
    q.phase == PH_RUN && ovlTrip && !forceOff && !q.sense.overTemp
    |=> power_good_oe && drive.inrushLimit)
    else $error("overload trip did not drop power-good");

  a_ovl_count_clr: assert property (
    @(posedge clk) disable iff (!resetn)
    !q.sense.overload |=> q.ovlCount == '0)
    else $error("deglitch counter not cleared");

  a_hot_all_off: assert property (
    @(posedge clk) disable iff (!resetn)
    q.sense.overTemp |=> !drive.passEnable && !drive.mpsEnable
      && !drive.classRegEnable)
    else $error("over-temperature left a driver on");

  a_hot_exit_inrush: assert property (
    @(posedge clk) disable iff (!resetn)
    q.phase == PH_HOT && !q.sense.overTemp
    |=> q.phase == PH_INRUSH && power_good_oe)
    else $error("over-temperature exit not to inrush");

  a_force_off: assert property (
    @(posedge clk) disable iff (!resetn)
    forceOff |=> !drive.passEnable)
    else $error("switch on while forced off");

  a_inrush_pg_low: assert property (
    @(posedge clk) disable iff (!resetn)
    q.phase == PH_INRUSH |-> power_good_oe)
    else $error("power-good released during inrush");

  a_delay_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    q.phase == PH_INRUSH && q.delayOpen && !q.skipDelay
      && q.delayCount != DLY_MAX |=> power_good_oe)
    else $error("power-good released before inrush delay");

  a_uvlo_keep_pg: assert property (
    @(posedge clk) disable iff (!resetn)
    q.phase == PH_RUN && q.sense.uvloFall && !q.sense.overTemp
    |=> !power_good_oe && !drive.passEnable)
    else $error("lockout changed power-good");

  a_status_late: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(q.pgReleased) |-> !statusOe)
    else $error("status active before power-good release");

  a_status_due: assert property (
    @(posedge clk) disable iff (!resetn)
    q.pgReleased && !statusOe && q.statusCount == STA_MAX
    |=> statusOe)
    else $error("status outputs not enabled in time");

  a_tied_release: assert property (
    @(posedge clk) disable iff (!resetn)
    q.phase == PH_INRUSH && !forceOff && q.sense.inrushDone
      && !q.delayOpen |=> !drive.inrushLimit && !power_good_oe)
    else $error("tied delay select did not end inrush");

  a_relock_inrush: assert property (
    @(posedge clk) disable iff (!resetn)
    q.phase == PH_OFF && q.sense.uvloRise && !forceOff
    |=> drive.passEnable && drive.inrushLimit && power_good_oe)
    else $error("restart without inrush limit");

  a_idle_detect: assert property (
    @(posedge clk) disable iff (!resetn)
    q.phase == PH_OFF && q.sense.disableLow
    |=> detectSuppress && !drive.passEnable)
    else $error("disable pin ignored while idle");

  a_hpwr_code: assert property (
    @(posedge clk) disable iff (!resetn)
    q.pgReleased && statusOe && allocPower == ALLOC_HPWR
    |=> status == 3'h1)
    else $error("granted high-power code wrong");
endmodule

// ### pd_hotswap_pkg.sv
package pd_hotswap_pkg;

  localparam int CLK_MHZ = 100;
  // overload deglitch, in microseconds
  localparam int OVL_DEGLITCH_US = 1650;
  localparam int OVL_DEGLITCH_CYC = OVL_DEGLITCH_US * CLK_MHZ;
  // inrush completion delay, in microseconds
  localparam int INRUSH_DELAY_US = 81500;
  localparam int INRUSH_DELAY_CYC = INRUSH_DELAY_US * CLK_MHZ;
  // status outputs become active after power-good release, in microseconds
  localparam int STATUS_DELAY_US = 10;
  localparam int STATUS_DELAY_CYC = STATUS_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 24;

  // source classification inputs
  localparam logic [1:0] ALLOC_LOW = 2'h0;
  localparam logic [1:0] ALLOC_MID = 2'h1;
  localparam logic [1:0] ALLOC_HIGH = 2'h2;
  localparam logic [1:0] ALLOC_HPWR = 2'h3;

  typedef enum logic [1:0] {
    PH_OFF,
    PH_INRUSH,
    PH_RUN,
    PH_HOT
  } phase_t;

  typedef struct packed {
    logic overload;
    logic overTemp;
    logic uvloFall;
    logic uvloRise;
    logic disableLow;
    logic inrushDone;
  } sense_t;

  typedef struct packed {
    logic allocPowerHighN;
    logic allocPowerLowN;
    logic sourceTypeN;
  } code_t;

  typedef struct packed {
    logic passEnable;
    logic inrushLimit;
    logic classRegEnable;
    logic mpsEnable;
  } drive_t;

endpackage

// ### pd_converter_model.sv
`timescale 1ns/100ps
module pd_converter_model #(
  parameter int CHARGE = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic passEnable,
  input wire logic overload,
  input wire logic power_good_oe,
  output logic inrushDone,
  output logic converterRun
);
  int charge;
  // bulk capacitor charges only while the switch conducts
  always_ff @(posedge clk) begin
    if (!resetn || !passEnable) begin
      charge <= 0;
    end else if (charge < CHARGE) begin
      charge <= charge + 1;
    end
  end
  // current sits at the limit while the return node is overloaded
  assign inrushDone = (charge == CHARGE) && !overload;
  // pull-up on power-good: converter starts once pin is released
  assign converterRun = !power_good_oe;
endmodule

// ### pd_hotswap_sequencer_test.sv
`timescale 1ns/100ps
module pd_hotswap_sequencer_test;
  import pd_hotswap_pkg::*;
  localparam int OVL = 20;
  localparam int DLY = 50;
  localparam int STS = 5;
  logic clk, resetn, delaySel, type34, done, run;
  logic suppress, pgOut, pgOe, statusOe;
  logic [1:0] alloc;
  sense_t flags, senseIn;
  drive_t drive;
  code_t status;
  int bad_count, n_tests;

  always_comb begin
    senseIn = flags;
    senseIn.inrushDone = done;
  end

  pd_hotswap_sequencer #(.OVL_CYCLES(OVL), .DELAY_CYCLES(DLY),
    .STATUS_CYCLES(STS)) pd_hotswap_sequencer_inst (.clk(clk),
    .resetn(resetn), .senseRaw(senseIn), .inrush_delay_select(delaySel),
    .sourceIsType34(type34), .allocPower(alloc), .drive(drive),
    .detectSuppress(suppress), .power_good_out(pgOut),
    .power_good_oe(pgOe), .status(status), .statusOe(statusOe));

  pd_converter_model pd_converter_model_inst (.clk(clk), .resetn(resetn),
    .passEnable(drive.passEnable), .overload(flags.overload),
    .power_good_oe(pgOe),
    .inrushDone(done), .converterRun(run));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task stop_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function logic probe(input int k);
    case (k)
      0: return drive.passEnable;
      1: return pgOe;
      2: return statusOe;
      default: return drive.inrushLimit;
    endcase
  endfunction

  // bounded wait; running out ends the run
  task wait_for(input int k, input logic v, input int bound);
    int i;
    for (i = 0; i < bound && probe(k) !== v; i++) @(negedge clk);
    if (probe(k) !== v) begin
      chk("wait", 3'(probe(k)), 3'(v));
      stop_test();
    end
  endtask

  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    bad_count = 0;
    n_tests = 0;
    resetn = 1'b0;
    delaySel = 1'b1;
    type34 = 1'b1;
    alloc = 2'h3;
    flags = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("reset", {drive.passEnable, drive.inrushLimit, pgOe}, 3'h3);
    chk("reset code", status, 3'h7);
    chk("pg pin", 3'(pgOut), 3'h0);
    @(posedge clk) flags.disableLow <= 1'b1;
    idle(8);
    chk("suppress", {1'b0, suppress, drive.passEnable}, 3'h2);
    @(posedge clk) begin
      flags.disableLow <= 1'b0;
      flags.uvloRise <= 1'b1;
    end
    wait_for(0, 1'b1, 10);
    chk("inrush", {drive.inrushLimit, pgOe, statusOe}, 3'h6);
    idle(30);
    chk("delay hold", 3'(pgOe), 3'h1);
    wait_for(1, 1'b0, 60);
    chk("op limit", {1'b0, drive.inrushLimit, run}, 3'h1);
    chk("mps run", 3'(drive.mpsEnable), 3'h1);
    wait_for(2, 1'b1, STS + 4);
    chk("code", status, 3'h1);
    @(posedge clk) begin
      alloc <= 2'h1;
      type34 <= 1'b0;
    end
    idle(2);
    chk("code mid", status, 3'h5);
    @(posedge clk) flags.overload <= 1'b1;
    idle(OVL - 8);
    @(posedge clk) flags.overload <= 1'b0;
    idle(8);
    chk("glitch", {1'b0, pgOe, drive.inrushLimit}, 3'h0);
    @(posedge clk) flags.overload <= 1'b1;
    wait_for(1, 1'b1, OVL + 10);
    chk("ovl limit", 3'(drive.inrushLimit), 3'h1);
    @(posedge clk) flags.overload <= 1'b0;
    wait_for(1, 1'b0, 12);
    @(posedge clk) flags.overTemp <= 1'b1;
    wait_for(0, 1'b0, 10);
    chk("hot", {1'b0, drive.classRegEnable, drive.mpsEnable}, 3'h0);
    @(posedge clk) flags.overTemp <= 1'b0;
    wait_for(0, 1'b1, 10);
    chk("cool", {drive.inrushLimit, pgOe, drive.classRegEnable}, 3'h7);
    wait_for(1, 1'b0, DLY + 40);
    @(posedge clk) flags.disableLow <= 1'b1;
    wait_for(0, 1'b0, 10);
    @(posedge clk) begin
      flags.disableLow <= 1'b0;
      delaySel <= 1'b0;
    end
    wait_for(0, 1'b1, 10);
    wait_for(1, 1'b0, 25);
    @(posedge clk) begin
      flags.uvloFall <= 1'b1;
      flags.uvloRise <= 1'b0;
    end
    wait_for(0, 1'b0, 10);
    idle(5);
    chk("fall pg", 3'(pgOe), 3'h0);
    @(posedge clk) resetn <= 1'b0;
    @(posedge clk) begin
      resetn <= 1'b1;
      flags.uvloFall <= 1'b0;
      flags.uvloRise <= 1'b1;
    end
    wait_for(0, 1'b1, 10);
    chk("relock", {1'b0, drive.inrushLimit, pgOe}, 3'h3);
    stop_test();
  end
endmodule
